// ### hdl/i2ct_defs.svh
// register map, field positions, reset values and timing constants of the i2c trigger
`ifndef I2CT_DEFS_SVH
`define I2CT_DEFS_SVH
// ==========================================================
`define I2CT_NSLOT 16
`define I2CT_NREG 28
`define I2CT_CLK_NS 20
// word indices; byte offset is four times the index
`define I2CT_IX_CTRL 5'h00
`define I2CT_IX_PASS 5'h01
`define I2CT_IX_STAT 5'h02
`define I2CT_IX_TVEN 5'h03
`define I2CT_IX_THR0 5'h04
`define I2CT_IX_SLOT0 5'h0C
// control fields
`define I2CT_CT_ARM 4
`define I2CT_CT_PRST 5
`define I2CT_CT_ATD 6
// slot fields
`define I2CT_SL_CARE 15:8
`define I2CT_SL_EN 16
`define I2CT_SL_ADDR 17
`define I2CT_SL_DIR 19:18
`define I2CT_SL_INRW 20
`define I2CT_SL_ACKC 21
`define I2CT_SL_ACKV 22
`define I2CT_SL_OP 24:23
// writable bits
`define I2CT_WM_CTRL 32'h0000006F
`define I2CT_WM_PASS 32'h0000FFFF
`define I2CT_WM_TVEN 32'h000000FF
`define I2CT_WM_THR 32'h0003FFFF
`define I2CT_WM_SLOT 32'h01FFFFFF
// thresholds in ns, highest word first so that word 4 receives tsu_sta:
// thigh, tbuf, thd_dat, thd_sta, tlow, tsu_sto, tsu_dat, tsu_sta
`define I2CT_THR_RST {32'h0000003C, 32'h000001F4, 32'h00000005, 32'h000000A0, \
	32'h000000A0, 32'h000000A0, 32'h0000000A, 32'h000000A0}
`endif

// ### hdl/i2ct_pkg.sv
// types of the i2c protocol trigger
package i2ct_pkg;
	typedef enum logic [3:0] {
		I2CT_M_START = 4'h0,
		I2CT_M_RSTART = 4'h1,
		I2CT_M_EITHER = 4'h2,
		I2CT_M_STOP = 4'h3,
		I2CT_M_NACK = 4'h4,
		I2CT_M_SEQ = 4'h5,
		I2CT_M_ALL = 4'h6,
		I2CT_M_ANY = 4'h7,
		I2CT_M_TIMING = 4'h8
	} i2ct_meth_e;
	typedef struct packed {
		logic [2:0] scl_sh;
		logic [2:0] sda_sh;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic busy, first, sda_mv, hd_pend, stop_seen;
		logic [13:0] t_sclr, t_sclf, t_sda, t_stop;
		logic armed, triggered, trig, trig_start;
		logic [3:0] lvl;
		logic [15:0] matched, passes;
		logic [27:0][31:0] regs;
		logic aw_full, w_full, awrdy, wrdy, arrdy, bvalid, rvalid;
		logic [7:0] wa;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] rdata;
		logic [1:0] bresp, rresp;
	} i2ct_st_s;
endpackage : i2ct_pkg

// ### hdl/i2ct_top.sv
// i2c protocol trigger engine with axi4-lite register access
`timescale 1ns/100ps
`include "i2ct_defs.svh"
module i2ct_top #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic trig_out,
	output logic trig_at_start,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import i2ct_pkg::*;

	if (ADDR_W != 8) begin : g_bad_aw
		$error("ADDR_W must be 8, the decoder reads exactly eight address bits");
	end

	// ==========================================================
	// helpers
	function automatic logic slot_hit(input logic [31:0] c, input logic [7:0] b,
		input logic ack, input logic first);
		logic [7:0] v;
		logic [7:0] m;
		logic [7:0] p;
		logic ok;
		logic res;
		m = c[`I2CT_SL_CARE];
		v = b;
		if (c[`I2CT_SL_ADDR] && !c[`I2CT_SL_INRW]) begin
			v = {1'b0, b[7:1]};
			m = {1'b0, m[6:0]};
		end
		v = v & m;
		p = c[7:0] & m;
		ok = c[`I2CT_SL_EN] && (c[`I2CT_SL_ADDR] == first);
		if (c[`I2CT_SL_ADDR] && c[`I2CT_SL_DIR] == 2'h1 && b[0]) begin
			ok = 1'b0;
		end
		if (c[`I2CT_SL_ADDR] && c[`I2CT_SL_DIR] == 2'h2 && !b[0]) begin
			ok = 1'b0;
		end
		if (c[`I2CT_SL_ACKC] && ack != c[`I2CT_SL_ACKV]) begin
			ok = 1'b0;
		end
		unique case (c[`I2CT_SL_OP])
			2'h0: res = (v == p);
			2'h1: res = (v != p);
			2'h2: res = (v < p);
			2'h3: res = (v > p);
		endcase
		return ok && res;
	endfunction : slot_hit

	function automatic logic [3:0] last_en(input logic [15:0] en);
		logic [3:0] r;
		r = 4'h0;
		for (int k = 0; k < `I2CT_NSLOT; k++) begin
			if (en[k]) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction : last_en

	function automatic logic [13:0] sat_inc(input logic [13:0] t);
		return (&t) ? t : t + 14'h0001;
	endfunction : sat_inc

	function automatic logic [31:0] wmask(input logic [4:0] ix);
		if (ix == `I2CT_IX_CTRL) begin
			return `I2CT_WM_CTRL;
		end else if (ix == `I2CT_IX_PASS) begin
			return `I2CT_WM_PASS;
		end else if (ix == `I2CT_IX_TVEN) begin
			return `I2CT_WM_TVEN;
		end else if (ix >= `I2CT_IX_SLOT0) begin
			return `I2CT_WM_SLOT;
		end else if (ix >= `I2CT_IX_THR0) begin
			return `I2CT_WM_THR;
		end
		return 32'h00000000;
	endfunction : wmask

	// ==========================================================
	// bus observer
	i2ct_st_s s;
	i2ct_st_s n;
	logic scl, scl_p, sda, sda_p, scl_r, scl_f, sda_e;
	logic start_any, st_e, rs_e, stop_e, byte_e;
	logic [15:0] hit, en;
	logic [7:0] tv_evt, viol;
	logic [7:0][13:0] tv_meas;
	logic [3:0] last;
	logic seq_hit, atd_on, all_ok, cond, simple;
	i2ct_meth_e meth;

	assign scl = s.scl_sh[1];
	assign scl_p = s.scl_sh[2];
	assign sda = s.sda_sh[1];
	assign sda_p = s.sda_sh[2];
	assign scl_r = scl && !scl_p;
	assign scl_f = !scl && scl_p;
	assign sda_e = sda != sda_p;
	assign start_any = !sda && sda_p && scl && scl_p;
	assign stop_e = sda && !sda_p && scl && scl_p;
	assign st_e = start_any && !s.busy;
	assign rs_e = start_any && s.busy;
	assign byte_e = scl_r && s.busy && s.bitcnt == 4'h8;
	assign meth = i2ct_meth_e'(s.regs[`I2CT_IX_CTRL][3:0]);

	// ==========================================================
	// condition slots and timing checks
	for (genvar k = 0; k < `I2CT_NSLOT; k++) begin : g_slot
		assign en[k] = s.regs[`I2CT_IX_SLOT0 + k][`I2CT_SL_EN];
		assign hit[k] = byte_e && slot_hit(s.regs[`I2CT_IX_SLOT0 + k], s.shreg, sda, s.first);
	end

	// order: tsu_sta, tsu_dat, tsu_sto, tlow, thd_sta, thd_dat, tbuf, thigh
	assign tv_evt = {scl_f, st_e && s.stop_seen, sda_e && !scl && !scl_p,
		scl_f && s.hd_pend, scl_r, stop_e, scl_r && s.sda_mv, rs_e};
	assign tv_meas = {s.t_sclr, s.t_stop, s.t_sclf, s.t_sda, s.t_sclf, s.t_sclr,
		s.t_sda, s.t_sclr};
	for (genvar i = 0; i < 8; i++) begin : g_tv
		assign viol[i] = s.regs[`I2CT_IX_TVEN][i] && tv_evt[i] && (20'(tv_meas[i])
			* 20'(`I2CT_CLK_NS) < s.regs[`I2CT_IX_THR0 + i][19:0]);
	end

	assign last = last_en(en);
	assign seq_hit = byte_e && hit[s.lvl];
	assign atd_on = s.regs[`I2CT_IX_CTRL][`I2CT_CT_ATD] && meth == I2CT_M_SEQ
		&& s.regs[`I2CT_IX_SLOT0][`I2CT_SL_ADDR];
	assign all_ok = byte_e && (|(hit & en)) && (((s.matched | hit) & en) == en);
	assign simple = meth <= I2CT_M_NACK;

	always_comb begin
		unique case (meth)
			I2CT_M_START: cond = st_e;
			I2CT_M_RSTART: cond = rs_e;
			I2CT_M_EITHER: cond = start_any;
			I2CT_M_STOP: cond = stop_e;
			I2CT_M_NACK: cond = byte_e && sda;
			I2CT_M_SEQ: cond = seq_hit && s.lvl == last;
			I2CT_M_ALL: cond = all_ok;
			I2CT_M_ANY: cond = |(hit & en);
			I2CT_M_TIMING: cond = |viol;
			default: cond = 1'b0;
		endcase
		cond = cond && s.armed;
	end

	// ==========================================================
	// next state
	always_comb begin
		logic [4:0] wix;
		logic [4:0] rix;
		logic [31:0] bm;
		wix = s.wa[6:2];
		rix = s_axi_araddr[6:2];
		bm = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
		n = s;
		n.trig = 1'b0;
		n.scl_sh = {s.scl_sh[1:0], scl_pin};
		n.sda_sh = {s.sda_sh[1:0], sda_pin};
		n.t_sclr = scl_r ? 14'h0000 : sat_inc(s.t_sclr);
		n.t_sclf = scl_f ? 14'h0000 : sat_inc(s.t_sclf);
		n.t_sda = sda_e ? 14'h0000 : sat_inc(s.t_sda);
		n.t_stop = stop_e ? 14'h0000 : sat_inc(s.t_stop);
		if (scl_f) begin
			n.sda_mv = 1'b0;
			n.hd_pend = 1'b0;
		end
		// a data change in the same sample as the clock fall belongs to the new low phase
		if (sda_e && !scl) begin
			n.sda_mv = 1'b1;
		end
		if (scl_r && s.busy) begin
			n.shreg = {s.shreg[6:0], sda};
			n.bitcnt = s.bitcnt + 4'h1;
			if (byte_e) begin
				n.bitcnt = 4'h0;
				n.first = 1'b0;
			end
		end
		if (start_any) begin
			n.busy = 1'b1;
			n.first = 1'b1;
			n.bitcnt = 4'h0;
			n.hd_pend = 1'b1;
			n.stop_seen = 1'b0;
		end
		if (stop_e) begin
			n.busy = 1'b0;
			n.stop_seen = 1'b1;
		end
		// match progression
		if (s.armed && meth == I2CT_M_SEQ) begin
			if (seq_hit && s.lvl != last) begin
				n.lvl = s.lvl + 4'h1;
			end else if (atd_on && s.lvl != 4'h0 && (start_any || (byte_e && !hit[s.lvl]))) begin
				n.lvl = 4'h0;
			end
		end
		if (s.armed && meth == I2CT_M_ALL) begin
			n.matched = stop_e ? 16'h0000 : (s.matched | (hit & en));
		end
		if (cond) begin
			if (s.passes < s.regs[`I2CT_IX_PASS][15:0]) begin
				n.passes = s.passes + 16'h0001;
				if (s.regs[`I2CT_IX_CTRL][`I2CT_CT_PRST]) begin
					n.lvl = 4'h0;
					n.matched = 16'h0000;
				end
			end else begin
				n.trig = 1'b1;
				n.triggered = 1'b1;
				n.armed = 1'b0;
				n.trig_start = simple;
			end
		end
		// axi4-lite write
		if (s_axi_awvalid && s.awrdy) begin
			n.awrdy = 1'b0;
			n.aw_full = 1'b1;
			n.wa = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s.wrdy) begin
			n.wrdy = 1'b0;
			n.w_full = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s.aw_full && s.w_full && !s.bvalid) begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = 2'h0;
			if (wix >= 5'(`I2CT_NREG) || s.wa[1:0] != 2'h0 || s.wa[7]) begin
				n.bresp = 2'h2;
			end else begin
				n.regs[wix] = (s.regs[wix] & ~(bm & wmask(wix))) | (s.wdata & bm & wmask(wix));
				if (wix == `I2CT_IX_CTRL && s.wstrb[0] && s.wdata[`I2CT_CT_ARM]) begin
					n.armed = 1'b1;
					n.triggered = 1'b0;
					n.trig_start = 1'b0;
					n.lvl = 4'h0;
					n.passes = 16'h0000;
					n.matched = 16'h0000;
				end
			end
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
			n.awrdy = 1'b1;
			n.wrdy = 1'b1;
		end
		// axi4-lite read
		if (s_axi_arvalid && s.arrdy) begin
			n.arrdy = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = 2'h0;
			n.rdata = 32'h00000000;
			if (rix >= 5'(`I2CT_NREG) || s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[7]) begin
				n.rresp = 2'h2;
			end else if (rix == `I2CT_IX_STAT) begin
				n.rdata = {s.passes, 4'h0, s.lvl, 5'h00, s.trig_start, s.triggered, s.armed};
			end else begin
				n.rdata = s.regs[rix];
			end
		end
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arrdy = 1'b1;
		end
		if (srst) begin
			n = '0;
			n.scl_sh = 3'h7;
			n.sda_sh = 3'h7;
			// saturated timers keep the first interval after reset from flagging
			n.t_sclr = 14'h3FFF;
			n.t_sclf = 14'h3FFF;
			n.t_sda = 14'h3FFF;
			n.t_stop = 14'h3FFF;
			n.regs[11:4] = `I2CT_THR_RST;
			n.awrdy = 1'b1;
			n.wrdy = 1'b1;
			n.arrdy = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		s <= n;
	end

	assign trig_out = s.trig;
	assign trig_at_start = s.trig_start;
	assign s_axi_awready = s.awrdy;
	assign s_axi_wready = s.wrdy;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arrdy;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	start_detect_a: assert property ($fell(sda) && scl && $past(scl) |-> start_any)
		else $error("start not seen");
	arm_clear_a: assert property (s.aw_full && s.w_full && !s.bvalid && s.wa == 8'h00
		&& s.wstrb[0] && s.wdata[`I2CT_CT_ARM] |=> s.armed && !s.triggered && s.lvl == 4'h0
		&& s.passes == 16'h0000 && s.matched == 16'h0000) else $error("arm did not clear state");
	seq_step_a: assert property (cond == 1'b0 && s.armed && meth == I2CT_M_SEQ && seq_hit
		&& s.lvl != last |=> s.lvl == $past(s.lvl) + 4'h1)
		else $error("sequence level did not advance");
	pass_supp_a: assert property (cond && s.passes < s.regs[1][15:0] |=> !trig_out
		&& s.passes == $past(s.passes) + 16'h0001)
		else $error("pass not counted");
	pass_fire_a: assert property (cond && s.passes >= s.regs[1][15:0] |=> trig_out
		##1 !trig_out)
		else $error("trigger not one pulse");
	pass_restart_a: assert property (cond && s.passes < s.regs[1][15:0]
		&& s.regs[0][5] |=> s.lvl == 4'h0 && s.matched == 16'h0000)
		else $error("restart did not return to first slot");
	any_fire_a: assert property (s.armed && meth == I2CT_M_ANY && |(hit & en)
		&& s.passes == s.regs[1][15:0] |=> trig_out && !trig_at_start)
		else $error("any match missed");
	all_fire_a: assert property ($rose(trig_out) && $past(meth) == I2CT_M_ALL
		|-> $past(all_ok))
		else $error("all match fired early");
	simple_pos_a: assert property (s.armed && meth == I2CT_M_STOP && stop_e
		&& s.passes == s.regs[1][15:0] |=> trig_out && trig_at_start)
		else $error("stop trigger wrong");
	tv_fire_a: assert property (s.armed && meth == I2CT_M_TIMING && viol != 8'h00
		&& s.passes == s.regs[1][15:0] |=> trig_out)
		else $error("timing violation missed");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read answer late");
	seq_fire_a: assert property (s.armed && meth == I2CT_M_SEQ && seq_hit && s.lvl == last
		&& s.passes == s.regs[1][15:0] |=> trig_out && !trig_at_start)
		else $error("sequence end missed");
	nack_fire_a: assert property (s.armed && meth == I2CT_M_NACK && byte_e && sda
		&& s.passes == s.regs[1][15:0] |=> trig_out && trig_at_start)
		else $error("missing ack trigger wrong");

	seq_fire_c: cover property (meth == I2CT_M_SEQ && trig_out);
	tv_fire_c: cover property (meth == I2CT_M_TIMING && trig_out);
	restart_c: cover property (cond && s.regs[0][5] && s.passes < s.regs[1][15:0]);
	atd_c: cover property (atd_on && s.lvl != 4'h0 ##1 s.lvl == 4'h0);
endmodule : i2ct_top

// ### verification/i2ct_bus_model.sv
// bus model that plays master and slave on the observed i2c lines
`timescale 1ns/100ps
module i2ct_bus_model (
	input wire logic core_clk,
	output logic scl,
	output logic sda
);
	// half bit time in clock cycles; shortened to provoke timing faults
	int hp = 12;
	// released lines sit at the pull-up level
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt
	task automatic start_c;
		if (scl === 1'b0) begin
			sda <= 1'b1;
			wt(hp);
			scl <= 1'b1;
			wt(hp);
		end
		sda <= 1'b0;
		wt(hp);
		scl <= 1'b0;
		wt(hp);
	endtask : start_c
	// ninth bit is the receiver answer, 1 = nack
	task automatic put_byte(input logic [7:0] d, input logic nk);
		logic [8:0] v;
		v = {d, nk};
		for (int i = 8; i >= 0; i--) begin
			sda <= v[i];
			wt(hp);
			scl <= 1'b1;
			wt(hp);
			scl <= 1'b0;
			wt(1);
		end
	endtask : put_byte
	task automatic stop_c;
		sda <= 1'b0;
		wt(hp);
		scl <= 1'b1;
		wt(hp);
		sda <= 1'b1;
		wt(hp);
	endtask : stop_c
	task automatic xfer(input logic [7:0] a, input logic [23:0] d, input int n, input logic nk);
		start_c();
		put_byte(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			put_byte(d[23-8*i -: 8], (i == n - 1) ? nk : 1'b0);
		end
		stop_c();
	endtask : xfer
endmodule : i2ct_bus_model

// ### verification/tb_i2ct_top.sv
// self-checking bench of the i2c protocol trigger
`timescale 1ns/100ps
`include "i2ct_defs.svh"
module tb_i2ct_top;
	import i2ct_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid, trig_out, trig_at_start, scl, sda;
	int mismatches = 0;
	int cmp_count = 0;
	int trig_n = 0;
	int cyc = 0;
	always #10 core_clk = ~core_clk;
	i2ct_bus_model bus (.core_clk(core_clk), .scl(scl), .sda(sda));
	i2ct_top DUT (.core_clk(core_clk), .srst(srst), .scl_pin(scl), .sda_pin(sda),
		.trig_out(trig_out), .trig_at_start(trig_at_start), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// ==========================================================
	// common tasks
	always @(posedge core_clk) begin
		cyc++;
		if (trig_out === 1'b1) trig_n++;
		if (cyc == 60000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [4:0] ix, input logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		awaddr <= {1'b0, ix, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		r = bresp;
	endtask : wr
	task automatic rd(input logic [4:0] ix, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= {1'b0, ix, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : rd
	task automatic arm(input logic [7:0] c, input logic [31:0] p, s1, s2);
		wr(`I2CT_IX_PASS, p, rs);
		wr(`I2CT_IX_SLOT0, s1, rs);
		wr(5'h0D, s2, rs);
		wr(`I2CT_IX_CTRL, {24'h000000, c | 8'h10}, rs);
	endtask : arm
	task automatic trial(input logic [7:0] c, input logic [31:0] s1, s2, input logic [7:0] a,
		input logic [23:0] d, input logic nk, input logic e);
		int n0;
		arm(c, 32'h00000000, s1, s2);
		n0 = trig_n;
		bus.xfer(a, d, 3, nk);
		bus.wt(4);
		chk(trig_n - n0 == int'(e), "pattern trigger count");
		if (e) chk(trig_at_start === 1'b0, "trigger point not at end");
	endtask : trial
	// ==========================================================
	// scenarios
	task automatic t_regs;
		logic [31:0] d;
		logic [31:0] thr [8] = '{32'h000000A0, 32'h0000000A, 32'h000000A0, 32'h000000A0,
			32'h000000A0, 32'h00000005, 32'h000001F4, 32'h0000003C};
		for (int i = 0; i < 8; i++) begin
			rd(5'(`I2CT_IX_THR0 + i), d, rs);
			chk(d === thr[i], "threshold reset value");
		end
		wr(5'h1B, 32'hFFFFFFFF, rs);
		rd(5'h1B, d, rs);
		chk(d === 32'h01FFFFFF, "last slot readback");
		wr(5'h1B, 32'h00000000, rs);
		wr(5'h1C, 32'h00000001, rs);
		chk(rs === 2'b10, "unmapped write response");
		rd(5'h1C, d, rs);
		chk(rs === 2'b10, "unmapped read response");
		$display("test regs done");
	endtask : t_regs
	task automatic t_simple;
		logic [4:0] e1 = 5'h05;
		logic [4:0] e2 = 5'h17;
		int n0;
		for (int m = 0; m < 5; m++) begin
			arm(8'(m), 32'h00000000, 32'h00000000, 32'h00000000);
			n0 = trig_n;
			bus.start_c();
			bus.put_byte(8'h8A, 1'b0);
			chk(trig_n - n0 == int'(e1[m]), "after first start");
			bus.start_c();
			bus.put_byte(8'h8B, 1'b1);
			chk(trig_n - n0 == int'(e2[m]), "after restart and nack");
			bus.stop_c();
			bus.wt(4);
			chk(trig_n - n0 == 1, "after stop");
			chk(trig_at_start === 1'b1, "trigger point not at start");
		end
		$display("test simple methods done");
	endtask : t_simple
	task automatic t_match;
		logic [31:0] sl [11] = '{32'h00037F45, 32'h00077F45, 32'h000B7F45, 32'h0013FF8B,
			32'h0013FF8B, 32'h00010F00, 32'h00010F00, 32'h0061FF21, 32'h0061FF21,
			32'h0181FF30, 32'h0101FF30};
		logic [7:0] ad [11] = '{8'h8A, 8'h8B, 8'h8B, 8'h8A, 8'h8B, 8'h8B, 8'h10, 8'h8A, 8'h8A,
			8'h8A, 8'h8A};
		logic [7:0] dd [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h21, 8'h21, 8'h21,
			8'h31, 8'h31};
		logic [10:0] nk = 11'h100;
		logic [10:0] ex = 11'h335;
		for (int i = 0; i < 11; i++) begin
			trial({4'h0, I2CT_M_ANY}, sl[i], 32'h0, ad[i], {16'h5A5A, dd[i]}, nk[i], ex[i]);
		end
		$display("test slot match done");
	endtask : t_match
	task automatic t_multi;
		logic [7:0] c [9] = '{8'h05, 8'h05, 8'h06, 8'h06, 8'h07, 8'h45, 8'h05, 8'h46, 8'h45};
		logic [23:0] d [9] = '{24'h11225A, 24'h22115A, 24'h22115A, 24'h33225A, 24'h33225A,
			24'h33225A, 24'h33225A, 24'h33225A, 24'h113322};
		logic [8:0] as = 9'h0E0;
		logic [8:0] ex = 9'h1D5;
		for (int i = 0; i < 9; i++) begin
			trial(c[i], as[i] ? 32'h00037F45 : 32'h0001FF11, 32'h0001FF22, 8'h8A, d[i], 1'b0, ex[i]);
		end
		$display("test evaluation modes done");
	endtask : t_multi
	task automatic t_pass(input logic [7:0] c, input logic [31:0] p, input logic [71:0] d);
		int n0;
		arm(c, p, 32'h0001FF11, 32'h0001FF22);
		n0 = trig_n;
		for (int i = 0; i < 3; i++) begin
			bus.xfer(8'h8A, d[71-24*i -: 24], 3, 1'b0);
			bus.wt(4);
			chk(trig_n - n0 == int'(i == 2), "pass count");
		end
		$display("test pass count done");
	endtask : t_pass
	task automatic t_timing;
		logic [7:0] en [5] = '{8'h08, 8'h08, 8'h80, 8'h80, 8'h40};
		int h [5] = '{12, 6, 12, 2, 12};
		logic [4:0] ex = 5'h1A;
		int n0;
		for (int i = 0; i < 5; i++) begin
			wr(`I2CT_IX_TVEN, {24'h000000, en[i]}, rs);
			bus.hp = h[i];
			arm({4'h0, I2CT_M_TIMING}, 32'h00000000, 32'h00000000, 32'h00000000);
			n0 = trig_n;
			bus.xfer(8'h8A, 24'h000000, 1, 1'b0);
			bus.xfer(8'h8A, 24'h000000, 1, 1'b0);
			bus.wt(4);
			chk(trig_n - n0 == int'(ex[i]), "timing violation");
		end
		bus.hp = 12;
		$display("test timing done");
	endtask : t_timing
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		t_regs();
		t_simple();
		t_match();
		t_multi();
		t_pass(8'h07, 32'h00000002, {3{24'h115A5A}});
		t_pass(8'h25, 32'h00000001, {24'h11225A, 24'h225A5A, 24'h11225A});
		t_timing();
		end_of_test();
	end
endmodule : tb_i2ct_top
